// ### design/ulf_line_format.sv
// Purpose: Line format register, register-set selection, transmit framing
//          and receive format/parity checking for one serial channel
// Assumes: All inputs come from logic on core_clk; the register port is
//          the decoded write/read path of the host serial interface
// Notes:   Format changes apply from the next character start; set selection acts from the next clock edge, break on the line one edge later

`timescale 1ns/10ps
`default_nettype none

module ulf_line_format (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Format register access
  input  wire logic       fmt_wr,
  input  wire logic [7:0] fmt_wdata,
  output logic      [7:0] fmt_rdata,
  // Register set selection
  output logic            divisor_latch_en,
  output logic            bank_normal,
  output logic            bank_special,
  output logic            bank_enhanced,
  // Baud timing
  input  wire logic       tick16,
  // Transmit side
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            tx_line,
  // Receive format and check
  input  wire logic       rx_char_start,
  output logic      [3:0] rx_word_bits,
  output logic      [5:0] rx_stop_ticks,
  output logic            rx_parity_en,
  input  wire logic       rx_check_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_parity_in,
  output logic            rx_parity_err,
  // FIFO clear
  input  wire logic       tx_fifo_rst_req,
  input  wire logic       rx_fifo_rst_req,
  output logic            tx_fifo_clr,
  output logic            rx_fifo_clr
);

  // ****************************************
  // Helpers
  // ****************************************
  // Next value of a FIFO clear counter
  function automatic logic [1:0] clr_next(input logic       req,
                                          input logic [1:0] cnt);
    if (req)
      clr_next = ulf_pkg::FIFO_CLR_CYCLES;
    else if (cnt != 2'h0)
      clr_next = cnt - 2'h1;
    else
      clr_next = 2'h0;
  endfunction : clr_next

  // ****************************************
  // Format register and register-set map
  // ****************************************
  logic [7:0] fmt;                 // Live line format byte
  logic [7:0] next_fmt;            // Next format byte
  logic       next_latch;          // Next divisor latch access
  logic       next_normal;         // Next normal set select
  logic       next_special;        // Next special set select
  logic       next_enhanced;       // Next enhanced set select

  // Write takes effect next edge; maps follow the same byte
  always_comb begin
    next_fmt = fmt_wr ? fmt_wdata : fmt;
    next_latch    = next_fmt[ulf_pkg::BIT_LATCH];
    // Exactly one set is mapped at any time
    next_enhanced = (next_fmt == ulf_pkg::ENH_KEY);
    next_special  = next_fmt[ulf_pkg::BIT_LATCH]
                    && !next_enhanced;
    next_normal   = !next_fmt[ulf_pkg::BIT_LATCH];
  end

  // Register format and maps
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fmt              <= ulf_pkg::FMT_RESET;
      divisor_latch_en <= 1'b0;
      bank_normal      <= 1'b1;
      bank_special     <= 1'b0;
      bank_enhanced    <= 1'b0;
    end else begin
      fmt              <= next_fmt;
      divisor_latch_en <= next_latch;
      bank_normal      <= next_normal;
      bank_special     <= next_special;
      bank_enhanced    <= next_enhanced;
    end
  end

  // Readback is the stored byte itself
  assign fmt_rdata = fmt;

  // ****************************************
  // Transmit framing
  // ****************************************
  // Framer freezes format per character, break uses live bit
  ulf_tx_framer i_ulf_tx_framer (
    .core_clk (core_clk),
    .rst      (rst),
    .fmt      (fmt),
    .tick     (tick16),
    .tx_valid (tx_valid),
    .tx_data  (tx_data),
    .tx_ready (tx_ready),
    .tx_line  (tx_line)
  );

  // ****************************************
  // Receive format and parity check
  // ****************************************
  logic [7:0] rx_fmt;              // Format frozen at receive start
  logic [7:0] next_rx_fmt;         // Next frozen format
  logic [3:0] next_rx_bits;        // Next data bit count
  logic [5:0] next_rx_stop;        // Next stop length
  logic       next_rx_par_en;      // Next parity enable
  logic       next_rx_err;         // Next parity error flag

  // Snapshot on start; check uses the frozen copy
  always_comb begin
    next_rx_fmt    = rx_char_start ? fmt : rx_fmt;
    next_rx_bits   = ulf_pkg::word_bits(next_rx_fmt);
    next_rx_stop   = ulf_pkg::stop_ticks(next_rx_fmt);
    next_rx_par_en = next_rx_fmt[ulf_pkg::BIT_PAR_EN];
    next_rx_err    = rx_parity_err;
    if (rx_check_valid) begin
      // Without parity nothing can be flagged
      if (rx_fmt[ulf_pkg::BIT_PAR_EN])
        next_rx_err = rx_parity_in
                      != ulf_pkg::parity_bit(rx_fmt, rx_data);
      else
        next_rx_err = 1'b0;
    end
  end

  // Register receive state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_fmt        <= ulf_pkg::FMT_RESET;
      rx_word_bits  <= ulf_pkg::WLEN_BASE;
      rx_stop_ticks <= ulf_pkg::STOP1_TICKS;
      rx_parity_en  <= 1'b0;
      rx_parity_err <= 1'b0;
    end else begin
      rx_fmt        <= next_rx_fmt;
      rx_word_bits  <= next_rx_bits;
      rx_stop_ticks <= next_rx_stop;
      rx_parity_en  <= next_rx_par_en;
      rx_parity_err <= next_rx_err;
    end
  end

  // ****************************************
  // FIFO clear stretchers
  // ****************************************
  logic [1:0] tx_clr_cnt;          // Transmit clear cycles left
  logic [1:0] rx_clr_cnt;          // Receive clear cycles left
  logic [1:0] next_tx_clr_cnt;     // Next transmit count
  logic [1:0] next_rx_clr_cnt;     // Next receive count

  // A request restarts the full clear window
  always_comb begin
    next_tx_clr_cnt = clr_next(tx_fifo_rst_req, tx_clr_cnt);
    next_rx_clr_cnt = clr_next(rx_fifo_rst_req, rx_clr_cnt);
  end

  // Clear outputs are flops, high while count runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_clr_cnt  <= 2'h0;
      rx_clr_cnt  <= 2'h0;
      tx_fifo_clr <= 1'b0;
      rx_fifo_clr <= 1'b0;
    end else begin
      tx_clr_cnt  <= next_tx_clr_cnt;
      rx_clr_cnt  <= next_rx_clr_cnt;
      tx_fifo_clr <= (next_tx_clr_cnt != 2'h0);
      rx_fifo_clr <= (next_rx_clr_cnt != 2'h0);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_latch_open;
    @(posedge core_clk) disable iff (rst)
    fmt_wr |=> divisor_latch_en == $past(fmt_wdata[ulf_pkg::BIT_LATCH]);
  endproperty
  a_latch_open: assert property (p_latch_open)
    else $error("divisor latch access does not follow bit 7");

  property p_break_low;
    @(posedge core_clk) disable iff (rst)
    (fmt[ulf_pkg::BIT_BREAK] && $past(fmt[ulf_pkg::BIT_BREAK]))
      |-> !tx_line;
  endproperty
  a_break_low: assert property (p_break_low)
    else $error("transmit line not low during break");

  sequence s_break_set;
    fmt[ulf_pkg::BIT_BREAK] && !fmt_wr;
  endsequence
  property p_break_hold;
    @(posedge core_clk) disable iff (rst)
    s_break_set |=> fmt[ulf_pkg::BIT_BREAK] ##1 !tx_line;
  endproperty
  a_break_hold: assert property (p_break_hold)
    else $error("break ended without a write");

  property p_rx_nopar;
    @(posedge core_clk) disable iff (rst)
    (rx_check_valid && !rx_fmt[ulf_pkg::BIT_PAR_EN]) |=> !rx_parity_err;
  endproperty
  a_rx_nopar: assert property (p_rx_nopar)
    else $error("parity error flagged with parity off");

  property p_rx_force;
    @(posedge core_clk) disable iff (rst)
    (rx_check_valid && rx_fmt[ulf_pkg::BIT_PAR_EN]
      && rx_fmt[ulf_pkg::BIT_FORCE])
      |=> rx_parity_err == ($past(rx_parity_in)
                            == $past(rx_fmt[ulf_pkg::BIT_EVEN]));
  endproperty
  a_rx_force: assert property (p_rx_force)
    else $error("forced parity checked wrongly");

  sequence s_clr_req;
    tx_fifo_rst_req;
  endsequence
  property p_clr_len;
    @(posedge core_clk) disable iff (rst)
    s_clr_req |=> tx_fifo_clr[*2];
  endproperty
  a_clr_len: assert property (p_clr_len)
    else $error("transmit FIFO clear shorter than two cycles");

  property p_rx_clr_len;
    @(posedge core_clk) disable iff (rst)
    rx_fifo_rst_req |=> rx_fifo_clr ##1 rx_fifo_clr;
  endproperty
  a_rx_clr_len: assert property (p_rx_clr_len)
    else $error("receive FIFO clear shorter than two cycles");

  property p_normal_map;
    @(posedge core_clk) disable iff (rst)
    bank_normal == !divisor_latch_en
      && $onehot({bank_normal, bank_special, bank_enhanced});
  endproperty
  a_normal_map: assert property (p_normal_map)
    else $error("normal set visible with latch access open");

  property p_enh_map;
    @(posedge core_clk) disable iff (rst)
    (fmt_wr && fmt_wdata == ulf_pkg::ENH_KEY) |=> bank_enhanced;
  endproperty
  a_enh_map: assert property (p_enh_map)
    else $error("enhanced set not mapped for key value");

  property p_spec_map;
    @(posedge core_clk) disable iff (rst)
    (fmt_wr && fmt_wdata[ulf_pkg::BIT_LATCH]
      && fmt_wdata != ulf_pkg::ENH_KEY) |=> bank_special;
  endproperty
  a_spec_map: assert property (p_spec_map)
    else $error("special set not mapped");

  property p_readback;
    @(posedge core_clk) disable iff (rst)
    fmt_wr |=> fmt_rdata == $past(fmt_wdata);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback differs from last write");

  property p_rx_len;
    @(posedge core_clk) disable iff (rst)
    rx_char_start
      |=> rx_word_bits == ulf_pkg::word_bits($past(fmt));
  endproperty
  a_rx_len: assert property (p_rx_len)
    else $error("receive word length not taken at start");

endmodule : ulf_line_format

`default_nettype wire

// ### design/ulf_pkg.sv
// Purpose: Shared constants, types and helpers for the line format block
// Assumes: 16x oversample tick from the baud generator, same clock domain
// Notes:   Format byte layout and timing counts live here only

package ulf_pkg;

  // ****************************************
  // Format byte layout
  // ****************************************
  localparam int          FMT_W       = 8;       // Register width
  localparam logic [7:0]  FMT_RESET   = 8'h00;   // All features off
  localparam logic [7:0]  ENH_KEY     = 8'hBF;   // Opens enhanced set
  localparam int          BIT_LATCH   = 7;       // Divisor latch access
  localparam int          BIT_BREAK   = 6;       // Forced break
  localparam int          BIT_FORCE   = 5;       // Forced parity
  localparam int          BIT_EVEN    = 4;       // Parity type
  localparam int          BIT_PAR_EN  = 3;       // Parity enable
  localparam int          BIT_STOP    = 2;       // Long stop
  localparam int          LEN_HI      = 1;       // Word length msb
  localparam int          LEN_LO      = 0;       // Word length lsb

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [5:0]  BIT_TICKS   = 6'h10;   // Ticks per bit time
  localparam logic [5:0]  STOP1_TICKS = 6'h10;   // One stop bit
  localparam logic [5:0]  STOP15_TICKS = 6'h18;  // One and a half
  localparam logic [5:0]  STOP2_TICKS = 6'h20;   // Two stop bits
  localparam logic [3:0]  WLEN_BASE   = 4'h5;    // Shortest word
  localparam logic [1:0]  LEN_5BIT    = 2'h0;    // 5-bit code
  localparam logic [1:0]  FIFO_CLR_CYCLES = 2'h2; // Least clear length

  // Transmit framer states, Gray along the frame when parity is on (data to stop without parity changes two bits)
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_DATA   = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP   = 3'h6
  } ulf_tx_state_e;

  // ****************************************
  // Helpers
  // ****************************************
  // Data bits per character
  function automatic logic [3:0] word_bits(input logic [7:0] fmt);
    word_bits = WLEN_BASE + {2'h0, fmt[LEN_HI:LEN_LO]};
  endfunction : word_bits

  // Stop length in 16x ticks
  function automatic logic [5:0] stop_ticks(input logic [7:0] fmt);
    if (!fmt[BIT_STOP])
      stop_ticks = STOP1_TICKS;
    else if (fmt[LEN_HI:LEN_LO] == LEN_5BIT)
      stop_ticks = STOP15_TICKS;
    else
      stop_ticks = STOP2_TICKS;
  endfunction : stop_ticks

  // Parity bit for the active word length
  function automatic logic parity_bit(input logic [7:0] fmt,
                                      input logic [7:0] data);
    logic [7:0] mask;
    logic       ones;
    mask = 8'hFF >> (4'h8 - word_bits(fmt));
    ones = ^(data & mask);
    if (fmt[BIT_FORCE])
      parity_bit = ~fmt[BIT_EVEN];
    else if (fmt[BIT_EVEN])
      parity_bit = ones;
    else
      parity_bit = ~ones;
  endfunction : parity_bit

endpackage : ulf_pkg

// ### design/ulf_tx_framer.sv
// Purpose: Serialises one character with the latched line format
// Assumes: tick is a one-cycle 16x oversample strobe on core_clk
// Notes:   Break uses the live format so it acts between characters too

`timescale 1ns/10ps
`default_nettype none

module ulf_tx_framer (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Format
  input  wire logic [7:0] fmt,
  input  wire logic       tick,
  // Character in
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // Line
  output logic            tx_line
);

  // ****************************************
  // Frame state
  // ****************************************
  ulf_pkg::ulf_tx_state_e st, next_st;     // Frame phase
  logic [7:0]  snap, next_snap;            // Format for this char
  logic [7:0]  shreg, next_shreg;          // Data bits, lsb first
  logic        par, next_par;              // Parity for this char
  logic [2:0]  bit_idx, next_bit_idx;      // Data bit index
  logic [5:0]  tcnt, next_tcnt;            // Ticks in current bit
  logic        next_line;                  // Line level to register
  logic        bit_end;                    // Last tick of a bit time

  assign bit_end  = tick && (tcnt == ulf_pkg::BIT_TICKS - 6'h1);
  assign tx_ready = (st == ulf_pkg::ST_IDLE);

  // Next frame state
  always_comb begin
    next_st      = st;
    next_snap    = snap;
    next_shreg   = shreg;
    next_par     = par;
    next_bit_idx = bit_idx;
    next_tcnt    = tick ? tcnt + 6'h1 : tcnt;
    next_line    = 1'b1;
    case (st)
      ulf_pkg::ST_IDLE: begin
        next_tcnt = 6'h0;
        if (tx_valid) begin
          // Format is frozen here for the whole character
          next_snap  = fmt;
          next_shreg = tx_data;
          next_par   = ulf_pkg::parity_bit(fmt, tx_data);
          next_st    = ulf_pkg::ST_START;
        end
      end
      ulf_pkg::ST_START: begin
        next_line = 1'b0;
        if (bit_end) begin
          next_tcnt    = 6'h0;
          next_bit_idx = 3'h0;
          next_st      = ulf_pkg::ST_DATA;
        end
      end
      ulf_pkg::ST_DATA: begin
        next_line = shreg[0];
        if (bit_end) begin
          next_tcnt  = 6'h0;
          next_shreg = {1'b0, shreg[7:1]};
          if ({1'b0, bit_idx} == ulf_pkg::word_bits(snap) - 4'h1) begin
            // Parity slot only when enabled
            next_st = snap[ulf_pkg::BIT_PAR_EN] ? ulf_pkg::ST_PARITY
                                                : ulf_pkg::ST_STOP;
          end else begin
            next_bit_idx = bit_idx + 3'h1;
          end
        end
      end
      ulf_pkg::ST_PARITY: begin
        next_line = par;
        if (bit_end) begin
          next_tcnt = 6'h0;
          next_st   = ulf_pkg::ST_STOP;
        end
      end
      ulf_pkg::ST_STOP: begin
        next_line = 1'b1;
        // 16x tick granularity covers the 1.5 stop case
        if (tick && tcnt == ulf_pkg::stop_ticks(snap) - 6'h1) begin
          next_tcnt = 6'h0;
          next_st   = ulf_pkg::ST_IDLE;
        end
      end
      default: begin
        next_st = ulf_pkg::ST_IDLE;
      end
    endcase
    // Break overrides everything while the bit stays set
    if (fmt[ulf_pkg::BIT_BREAK])
      next_line = 1'b0;
  end

  // Register frame state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st      <= ulf_pkg::ST_IDLE;
      snap    <= ulf_pkg::FMT_RESET;
      shreg   <= 8'h00;
      par     <= 1'b0;
      bit_idx <= 3'h0;
      tcnt    <= 6'h0;
      tx_line <= 1'b1;
    end else begin
      st      <= next_st;
      snap    <= next_snap;
      shreg   <= next_shreg;
      par     <= next_par;
      bit_idx <= next_bit_idx;
      tcnt    <= next_tcnt;
      tx_line <= next_line;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] chk_data;   // Original data, kept for the parity check
  logic [5:0] chk_stop;   // Ticks seen in the stop phase
  logic [3:0] chk_bits;   // Data bits completed, apart from bit_idx
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chk_data <= 8'h00;
      chk_stop <= 6'h0;
      chk_bits <= 4'h0;
    end else begin
      if (st == ulf_pkg::ST_IDLE && tx_valid)
        chk_data <= tx_data;
      if (st != ulf_pkg::ST_STOP)
        chk_stop <= 6'h0;
      else if (tick)
        chk_stop <= chk_stop + 6'h1;
      // Own count, so a broken bit index cannot hide itself
      if (st != ulf_pkg::ST_DATA)
        chk_bits <= 4'h0;
      else if (bit_end)
        chk_bits <= chk_bits + 4'h1;
    end
  end

  property p_par_value;
    @(posedge core_clk) disable iff (rst)
    (st == ulf_pkg::ST_PARITY && !fmt[ulf_pkg::BIT_BREAK])
      |=> tx_line == ulf_pkg::parity_bit(snap, chk_data);
  endproperty
  a_par_value: assert property (p_par_value)
    else $error("parity bit on the line is wrong");

  property p_word_len;
    @(posedge core_clk) disable iff (rst)
    (st == ulf_pkg::ST_DATA && next_st != ulf_pkg::ST_DATA)
      |-> chk_bits + 4'h1 == ulf_pkg::word_bits(snap);
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("wrong number of data bits sent");

  property p_stop_len;
    @(posedge core_clk) disable iff (rst)
    (st == ulf_pkg::ST_STOP && next_st == ulf_pkg::ST_IDLE)
      |-> chk_stop + 6'h1 == ulf_pkg::stop_ticks(snap);
  endproperty
  a_stop_len: assert property (p_stop_len)
    else $error("stop phase has the wrong length");

  property p_snap_hold;
    @(posedge core_clk) disable iff (rst)
    (st != ulf_pkg::ST_IDLE && $past(st) != ulf_pkg::ST_IDLE)
      |-> snap == $past(snap);
  endproperty
  a_snap_hold: assert property (p_snap_hold)
    else $error("format changed inside a character");

endmodule : ulf_tx_framer

`default_nettype wire

// ### tb/ulf_line_format_tb_top.sv
// Purpose: Self-checking bench for the line format block
// Assumes: tick16 held high, so a bit time is 16 clocks
// Notes:   Inputs change on the falling edge only

`timescale 1ns/10ps
`default_nettype none

module ulf_line_format_tb_top;
  logic       core_clk, rst, fmt_wr, tx_valid, tx_ready, tx_line, rxs, rxc;
  logic       rx_par_in, par_err, tfr, rfr, tclr, rclr, dle, bn, bs, be;
  logic [7:0] fmt_wdata, fmt_rdata, tx_data, rx_data, got_data;
  logic [3:0] rwb, nbits;
  logic [5:0] rst_ticks;
  logic       rpe, par_en, got_par, got_done;
  int         err_total, check_count, cyc;

  ulf_line_format i_ulf_line_format (.core_clk(core_clk), .rst(rst),
    .fmt_wr(fmt_wr), .fmt_wdata(fmt_wdata), .fmt_rdata(fmt_rdata),
    .divisor_latch_en(dle), .bank_normal(bn), .bank_special(bs),
    .bank_enhanced(be), .tick16(1'b1), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_line(tx_line),
    .rx_char_start(rxs), .rx_word_bits(rwb), .rx_stop_ticks(rst_ticks),
    .rx_parity_en(rpe), .rx_check_valid(rxc), .rx_data(rx_data),
    .rx_parity_in(rx_par_in), .rx_parity_err(par_err),
    .tx_fifo_rst_req(tfr), .rx_fifo_rst_req(rfr),
    .tx_fifo_clr(tclr), .rx_fifo_clr(rclr));
  ulf_remote_term i_ulf_remote_term (.core_clk(core_clk), .line(tx_line),
    .nbits(nbits), .par_en(par_en), .got_data(got_data),
    .got_par(got_par), .got_done(got_done));

  // ****************************************
  // Clock and timeout
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Cut a hang well past the longest expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  // Compare and count
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (exp !== got) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] v);
    fmt_wr = 1'b1; fmt_wdata = v;
    @(negedge core_clk);
    fmt_wr = 1'b0;
    // Idle cycle keeps the strobe from being set twice in one step
    @(negedge core_clk);
  endtask : wr

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_banks();
    chk("reset value", 8'h00, fmt_rdata);
    chk("reset banks", 8'h01, {4'h0, dle, bs, be, bn});
    wr(8'h80);
    chk("special", 8'h0C, {4'h0, dle, bs, be, bn});
    wr(8'hBF);
    chk("enhanced", 8'h0A, {4'h0, dle, bs, be, bn});
    // No break here, so the terminal sees no false frame
    wr(8'h1F);
    chk("readback", 8'h1F, fmt_rdata);
    chk("normal", 8'h01, {4'h0, dle, bs, be, bn});
  endtask : t_banks

  // Send one character and judge data, parity and frame length
  task automatic t_frame(logic [7:0] f, logic [7:0] d);
    int n, st, len;
    logic p;
    n = 5 + f[1:0];
    st = !f[2] ? 16 : (f[1:0] == 2'h0 ? 24 : 32);
    p = ^(d & (8'hFF >> (8 - n)));
    p = f[5] ? ~f[4] : (f[4] ? p : ~p);
    nbits = n[3:0]; par_en = f[3];
    wr(f);
    tx_data = d; tx_valid = 1'b1;
    @(negedge core_clk);
    tx_valid = 1'b0; len = 0;
    while (!tx_ready && len < 400) begin
      @(negedge core_clk);
      len++;
    end
    chk("data", d & (8'hFF >> (8 - n)), got_data);
    if (f[3]) chk("parity", {7'h0, p}, {7'h0, got_par});
    len = len - 16 * (1 + n + f[3]) - st;
    chk("frame length", 8'h00, (len > 2 || len < -2) ? 8'hFF : 8'h00);
  endtask : t_frame

  task automatic t_break();
    wr(8'h43);
    repeat (40) @(negedge core_clk);
    chk("break line", 8'h00, {7'h0, tx_line});
    wr(8'h03);
    @(negedge core_clk);
    chk("break off", 8'h01, {7'h0, tx_line});
  endtask : t_break

  task automatic t_rx();
    wr(8'h1F);
    rxs = 1'b1; @(negedge core_clk); rxs = 1'b0;
    chk("rx format", 8'h81, {rwb, 3'h0, rpe});
    chk("rx stop", 8'h20, {2'h0, rst_ticks});
    rx_data = 8'h03; rx_par_in = 1'b1; rxc = 1'b1;
    @(negedge core_clk);
    chk("rx even bad", 8'h01, {7'h0, par_err});
    rx_par_in = 1'b0;
    @(negedge core_clk);
    rxc = 1'b0;
    chk("rx even ok", 8'h00, {7'h0, par_err});
    wr(8'h00);
    chk("rx held", 8'h01, {7'h0, rpe});
    rxs = 1'b1; @(negedge core_clk); rxs = 1'b0;
    rx_par_in = 1'b1; rxc = 1'b1; @(negedge core_clk); rxc = 1'b0;
    chk("rx no parity", 8'h00, {7'h0, par_err});
    // Odd, 5 bits: 0x03 has two ones, so parity 1 is wanted
    wr(8'h08);
    rxs = 1'b1; @(negedge core_clk); rxs = 1'b0;
    rx_par_in = 1'b0; rxc = 1'b1; @(negedge core_clk); rxc = 1'b0;
    chk("rx odd bad", 8'h01, {7'h0, par_err});
    // Forced zero accepts a zero parity bit
    wr(8'h38);
    rxs = 1'b1; @(negedge core_clk); rxs = 1'b0;
    rx_par_in = 1'b0; rxc = 1'b1; @(negedge core_clk); rxc = 1'b0;
    chk("rx forced zero", 8'h00, {7'h0, par_err});
    // Forced one refuses a zero parity bit
    wr(8'h28);
    rxs = 1'b1; @(negedge core_clk); rxs = 1'b0;
    rx_par_in = 1'b0; rxc = 1'b1; @(negedge core_clk); rxc = 1'b0;
    chk("rx forced one", 8'h01, {7'h0, par_err});
  endtask : t_rx

  task automatic t_fifo();
    tfr = 1'b1; rfr = 1'b1; @(negedge core_clk); tfr = 1'b0; rfr = 1'b0;
    chk("clr c1", 8'h03, {6'h0, tclr, rclr});
    @(negedge core_clk);
    chk("clr c2", 8'h03, {6'h0, tclr, rclr});
    @(negedge core_clk);
    chk("clr end", 8'h00, {6'h0, tclr, rclr});
  endtask : t_fifo

  task automatic close_out();
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1; fmt_wr = 1'b0; fmt_wdata = 8'h00; tx_valid = 1'b0;
    tx_data = 8'h00; rxs = 1'b0; rxc = 1'b0; rx_data = 8'h00;
    rx_par_in = 1'b0; tfr = 1'b0; rfr = 1'b0; nbits = 4'h8; par_en = 1'b0;
    err_total = 0; check_count = 0; cyc = 0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_banks();
    t_frame(8'h00, 8'h15);
    t_frame(8'h0D, 8'h2A);
    t_frame(8'h1E, 8'h5B);
    t_frame(8'h2B, 8'hA5);
    t_frame(8'h3C, 8'h0E);
    t_break();
    t_rx();
    t_fifo();
    close_out();
  end
endmodule : ulf_line_format_tb_top

`default_nettype wire

// ### tb/ulf_remote_term.sv
// Purpose: Remote terminal that decodes frames seen on the transmit line
// Assumes: One bit time is 16 core_clk cycles (tick16 held high)
// Notes:   Samples at mid-bit; no answer path toward the block

`timescale 1ns/10ps
`default_nettype none

module ulf_remote_term (
  // Clock and line
  input  wire logic       core_clk,
  input  wire logic       line,
  // Expected format
  input  wire logic [3:0] nbits,
  input  wire logic       par_en,
  // Decoded character
  output logic      [7:0] got_data,
  output logic            got_par,
  output logic            got_done
);
  // ****************************************
  // Frame decoder
  // ****************************************
  initial got_done = 1'b0;
  always begin
    @(negedge line);
    got_done = 1'b0;
    repeat (8) @(posedge core_clk);
    got_data = 8'h00;
    // Data lsb first
    for (int i = 0; i < nbits; i++) begin
      repeat (16) @(posedge core_clk);
      got_data[i] = line;
    end
    // Parity slot only when enabled
    if (par_en) begin
      repeat (16) @(posedge core_clk);
      got_par = line;
    end
    got_done = 1'b1;
  end
endmodule : ulf_remote_term

`default_nettype wire
